// [rtl/fcr_config_one.sv]
// Function
// - After power-on reset, bit 15 zero enters deep power down, one enters standby.
// - In deep power down, a chip select pulse or hardware reset returns standby.
// - Bits 14:12 select output impedance; 101 default gives 30 ohms.
// - Configuration lock bit 11 zero refuses configuration programming; one allows it.
// - Power-up and hardware reset return the configuration lock bit to one.
// - Secure-region lock bit 10 zero refuses secure region programming.
// - Bits 9:8 select sector map; default 10 uniform, password sector bottom.
// - Mapped 4KB block replaces part of the top or bottom large sector.
// - Bits 7:4 set dummy cycles for variable-latency reads; default 1011.
// - Latency code 0000 gives 5 cycles up to 1100 giving 20 cycles.
// - Erased register of all ones still yields 20 latency cycles.
// - Bit 2 zero stalls data strobe on device errors; one keeps toggling.
// - Bits 1:0 select wrap: 01 64, 10 16, 11 32 bytes, 00 reserved.
// - Wrapped bursts stay inside a group aligned to the wrap length.
// - Power-up, hardware or software reset copies non-volatile bits into volatile.
// - Non-volatile write updates volatile too; volatile write leaves non-volatile alone.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "fcr_regs.svh"

module fcr_config_one
    import fcr_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cs_n,
    input wire logic hw_reset_n,
    output logic deep_power_down,
    output logic [7:0] drive_impedance_ohm,
    output logic config_prog_allowed,
    output logic ssr_prog_allowed,
    output logic small_sector_en,
    output logic small_sector_top,
    output logic password_sector_top,
    output logic [4:0] read_latency_cycles,
    output logic strobe_stall_en,
    output logic [6:0] wrap_len_bytes,
    output logic [5:0] wrap_addr_mask
);

    // Offsets up to 0x0C need at least four address bits
    if (ADDR_W < 4)
    begin : g_addr_w_check
        $error("ADDR_W too narrow for the register map");
    end

    // ----------------------------------------
    // Decode and byte-merge functions
    // ----------------------------------------
    function automatic logic [7:0] imped_ohm(input logic [2:0] sel);
        logic [7:0] r;
        r = 8'h2D;
        case (sel)
            3'h1: r = 8'h78;
            3'h2: r = 8'h5A;
            3'h3: r = 8'h3C;
            3'h5: r = 8'h1E;
            3'h6: r = 8'h14;
            3'h7: r = 8'h0F;
            default: r = 8'h2D;
        endcase
        return r;
    endfunction

    function automatic logic [4:0] lat_cycles(input logic [3:0] code);
        logic [4:0] r;
        // Codes above the top one (erased included) fall back to the slowest
        if (code < `FCR_LAT_TOP_CODE)
        begin
            r = `FCR_LAT_BASE + {1'b0, code};
        end
        else
        begin
            r = `FCR_LAT_MAX;
        end
        return r;
    endfunction

    function automatic logic [6:0] wrap_bytes(input logic [1:0] sel);
        logic [6:0] r;
        case (sel)
            2'h1: r = `FCR_WRAP_64;
            2'h2: r = `FCR_WRAP_16;
            // Reserved code served as the default 32-byte wrap
            default: r = `FCR_WRAP_32;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0])
        begin
            r[7:0] = d[7:0];
        end
        if (be[1])
        begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] cs_sync_r;
    logic cs_prev_r;
    logic [1:0] hw_sync_r;
    logic hw_prev_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_sync_r <= 2'b11;
            cs_prev_r <= 1'b1;
            hw_sync_r <= 2'b11;
            hw_prev_r <= 1'b1;
        end
        else
        begin
            cs_sync_r <= {cs_sync_r[0], cs_n};
            cs_prev_r <= cs_sync_r[1];
            hw_sync_r <= {hw_sync_r[0], hw_reset_n};
            hw_prev_r <= hw_sync_r[1];
        end
    end

    logic cs_rise;
    logic hw_release;
    logic hw_active;
    assign cs_rise = cs_sync_r[1] & ~cs_prev_r;
    assign hw_release = hw_sync_r[1] & ~hw_prev_r;
    assign hw_active = ~hw_sync_r[1];

    // ----------------------------------------
    // APB access
    // ----------------------------------------
    fcr_cfg_type nv_r;
    fcr_cfg_type v_r;
    fcr_pwr_type pwr_r;
    logic por_load_r;

    logic acc;
    logic wr_done;
    logic hit_nv;
    logic hit_v;
    logic hit_st;
    logic hit_ctl;
    logic locked;
    assign acc = psel & penable & ~pready;
    assign wr_done = psel & penable & pready & pwrite & ~pslverr;
    assign hit_nv = paddr == ADDR_W'(`FCR_OFS_NONVOL);
    assign hit_v = paddr == ADDR_W'(`FCR_OFS_VOL);
    assign hit_st = paddr == ADDR_W'(`FCR_OFS_STATUS);
    assign hit_ctl = paddr == ADDR_W'(`FCR_OFS_CTRL);
    assign locked = ~v_r.config_lock;

    logic [31:0] status_word;
    assign status_word = {21'h0, read_latency_cycles, 1'b0, config_prog_allowed,
                          ssr_prog_allowed, pwr_r, deep_power_down};

    // Answer one cycle into the access phase, so a write lands on the sampled edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= acc;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (acc)
            begin
                if (pwrite)
                begin
                    pslverr <= ~(hit_nv | hit_v | hit_ctl) |
                               ((hit_nv | hit_v) & locked);
                end
                else if (hit_nv)
                begin
                    prdata <= {16'h0, nv_r};
                end
                else if (hit_v)
                begin
                    prdata <= {16'h0, v_r};
                end
                else if (hit_st)
                begin
                    prdata <= status_word;
                end
                else
                begin
                    pslverr <= ~hit_ctl;
                end
            end
        end
    end

    // ----------------------------------------
    // Register copies
    // ----------------------------------------
    logic sw_reset;
    logic erase;
    logic enter_dpd;
    assign sw_reset = wr_done & hit_ctl & pstrb[0] & pwdata[`FCR_CTRL_SW_RESET];
    assign erase = wr_done & hit_ctl & pstrb[0] & pwdata[`FCR_CTRL_ERASE] & ~locked;
    assign enter_dpd = wr_done & hit_ctl & pstrb[0] & pwdata[`FCR_CTRL_ENTER_DPD];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            por_load_r <= 1'b1;
        end
        else
        begin
            por_load_r <= 1'b0;
        end
    end

    // Non-volatile copy survives hardware and software reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nv_r <= `FCR_FACTORY_DEFAULT;
        end
        else if (erase)
        begin
            nv_r <= `FCR_ERASED;
        end
        else if (wr_done & hit_nv)
        begin
            nv_r <= merge16(nv_r, pwdata, pstrb);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            v_r <= `FCR_FACTORY_DEFAULT;
        end
        else if (por_load_r | hw_active)
        begin
            v_r <= nv_r;
            v_r.config_lock <= 1'b1;
            v_r.secure_region_lock <= 1'b1;
        end
        else if (sw_reset)
        begin
            // Software reset keeps the temporary locks as they stand
            v_r <= nv_r;
            v_r.config_lock <= v_r.config_lock;
            v_r.secure_region_lock <= v_r.secure_region_lock;
        end
        else if (erase)
        begin
            v_r <= `FCR_ERASED;
        end
        else if (wr_done & (hit_nv | hit_v))
        begin
            v_r <= merge16(v_r, pwdata, pstrb);
        end
    end

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_r <= FCR_BOOT;
        end
        else
        begin
            case (pwr_r)
                FCR_BOOT:
                begin
                    pwr_r <= nv_r.post_reset_power_state ? FCR_STANDBY : FCR_DPD;
                end
                FCR_STANDBY:
                begin
                    if (enter_dpd)
                    begin
                        pwr_r <= FCR_DPD;
                    end
                end
                FCR_DPD:
                begin
                    if (cs_rise | hw_release)
                    begin
                        pwr_r <= FCR_STANDBY;
                    end
                end
                default:
                begin
                    pwr_r <= FCR_BOOT;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registered decoded outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deep_power_down <= 1'b0;
            drive_impedance_ohm <= 8'h1E;
            config_prog_allowed <= 1'b1;
            ssr_prog_allowed <= 1'b1;
            small_sector_en <= 1'b0;
            small_sector_top <= 1'b0;
            password_sector_top <= 1'b0;
            read_latency_cycles <= 5'h10;
            strobe_stall_en <= 1'b0;
            wrap_len_bytes <= `FCR_WRAP_32;
            wrap_addr_mask <= 6'h1F;
        end
        else
        begin
            deep_power_down <= pwr_r == FCR_DPD;
            drive_impedance_ohm <= imped_ohm(v_r.drive_strength_sel);
            config_prog_allowed <= v_r.config_lock;
            ssr_prog_allowed <= v_r.secure_region_lock;
            small_sector_en <= ~v_r.sector_map_sel[1];
            small_sector_top <= ~v_r.sector_map_sel[1] & v_r.sector_map_sel[0];
            password_sector_top <= v_r.sector_map_sel[0];
            read_latency_cycles <= lat_cycles(v_r.read_latency_sel);
            strobe_stall_en <= ~v_r.strobe_stall_on_error;
            wrap_len_bytes <= wrap_bytes(v_r.burst_wrap_len);
            wrap_addr_mask <= 6'(wrap_bytes(v_r.burst_wrap_len) - 7'h01);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_por_power_state: assert property (@(posedge pclk) disable iff (!presetn)
        (pwr_r == FCR_BOOT) |=> (pwr_r == (nv_r.post_reset_power_state ? FCR_STANDBY : FCR_DPD)))
        else $error("Power state after boot does not follow bit 15");
    a_dpd_cs_exit: assert property (@(posedge pclk) disable iff (!presetn)
        (pwr_r == FCR_DPD && cs_rise) |=> ##1 !deep_power_down)
        else $error("Chip select pulse did not leave deep power down");
    a_imped_map: assert property (@(posedge pclk) disable iff (!presetn)
        (v_r.drive_strength_sel == 3'h5) |=> (drive_impedance_ohm == 8'h1E))
        else $error("Default drive strength is not 30 ohm");
    a_lock_refuses: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && pwrite && hit_v && locked) |=> (pslverr && $stable(v_r)) ##1 $stable(v_r))
        else $error("Locked volatile write was not refused");
    a_hw_lock_restore: assert property (@(posedge pclk) disable iff (!presetn)
        hw_active |=> (v_r.config_lock && v_r.secure_region_lock))
        else $error("Hardware reset did not restore lock bits");
    a_nv_to_v_copy: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_reset && !hw_active && !por_load_r) |=> (v_r[9:0] == $past(nv_r[9:0])))
        else $error("Software reset did not copy non-volatile bits");
    a_vol_keeps_nv: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && hit_v) |=> $stable(nv_r))
        else $error("Volatile write changed the non-volatile copy");
    a_latency_top: assert property (@(posedge pclk) disable iff (!presetn)
        (v_r.read_latency_sel >= 4'hC) |=> (read_latency_cycles == 5'h14))
        else $error("Latency code at or above 1100 not 20 cycles");
    a_latency_base: assert property (@(posedge pclk) disable iff (!presetn)
        (v_r.read_latency_sel == 4'h0) |=> (read_latency_cycles == 5'h05))
        else $error("Latency code 0000 not 5 cycles");
    a_wrap_len: assert property (@(posedge pclk) disable iff (!presetn)
        (v_r.burst_wrap_len == 2'h2) |=> (wrap_len_bytes == 7'h10 && wrap_addr_mask == 6'h0F))
        else $error("Wrap code 10 not 16 bytes");
    a_stall_sel: assert property (@(posedge pclk) disable iff (!presetn)
        !v_r.strobe_stall_on_error |=> strobe_stall_en)
        else $error("Strobe stall not enabled for bit 2 zero");

endmodule

// [rtl/fcr_pkg.sv]
package fcr_pkg;

    typedef struct packed {
        logic post_reset_power_state;
        logic [2:0] drive_strength_sel;
        logic config_lock;
        logic secure_region_lock;
        logic [1:0] sector_map_sel;
        logic [3:0] read_latency_sel;
        logic reserved_bit;
        logic strobe_stall_on_error;
        logic [1:0] burst_wrap_len;
    } fcr_cfg_type;

    typedef enum logic [1:0] {
        FCR_BOOT = 2'b00,
        FCR_STANDBY = 2'b01,
        FCR_DPD = 2'b11
    } fcr_pwr_type;

endpackage

// [rtl/fcr_regs.svh]
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FCR_OFS_NONVOL 8'h00
`define FCR_OFS_VOL 8'h04
`define FCR_OFS_STATUS 8'h08
`define FCR_OFS_CTRL 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCR_BIT_PWR 15
`define FCR_BIT_CFG_LOCK 11
`define FCR_BIT_SSR_LOCK 10
`define FCR_CTRL_SW_RESET 0
`define FCR_CTRL_ERASE 1
`define FCR_CTRL_ENTER_DPD 2

// ----------------------------------------
// Reset and decode values
// ----------------------------------------
`define FCR_FACTORY_DEFAULT 16'hDEBF
`define FCR_ERASED 16'hFFFF
`define FCR_LAT_BASE 5'h05
`define FCR_LAT_TOP_CODE 4'hC
`define FCR_LAT_MAX 5'h14
`define FCR_WRAP_16 7'h10
`define FCR_WRAP_32 7'h20
`define FCR_WRAP_64 7'h40

`endif

// [tb/fcr_config_one_tb.sv]
`timescale 1ns/10ps
`include "fcr_regs.svh"

module fcr_config_one_tb
    import fcr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, cs_n, hw_reset_n, pready, pslverr, rerr;
    logic deep_power_down, config_prog_allowed, ssr_prog_allowed, strobe_stall_en;
    logic small_sector_en, small_sector_top, password_sector_top;
    logic [7:0] paddr, drive_impedance_ohm;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [4:0] read_latency_cycles;
    logic [6:0] wrap_len_bytes;
    logic [5:0] wrap_addr_mask;
    logic [15:0] v;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    fcr_config_one u_fcr_config_one (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .cs_n, .hw_reset_n, .deep_power_down,
        .drive_impedance_ohm, .config_prog_allowed, .ssr_prog_allowed, .small_sector_en,
        .small_sector_top, .password_sector_top, .read_latency_cycles, .strobe_stall_en,
        .wrap_len_bytes, .wrap_addr_mask);

    fcr_host_model u_fcr_host_model (.pclk, .cs_n, .hw_reset_n);

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Whole run needs about 350 cycles
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // ----
    // Helpers
    // ----
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] imp(input logic [2:0] c);
        case (c)
            3'h1: imp = 8'h78;
            3'h2: imp = 8'h5A;
            3'h3: imp = 8'h3C;
            3'h5: imp = 8'h1E;
            3'h6: imp = 8'h14;
            3'h7: imp = 8'h0F;
            default: imp = 8'h2D;
        endcase
    endfunction

    // Holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 40)
            miscompares++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
        apb(1'b1, a, d);
        check(32'(rerr), 32'(e));
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        check(rdat, exp);
        check(32'(rerr), 32'(a > 8'h0C));
        @(posedge pclk);
    endtask

    // Decoded outputs lag the volatile copy by a cycle
    task automatic outs(input logic [15:0] x);
        logic [6:0] wl;
        repeat (2) @(posedge pclk);
        wl = (x[1:0] == 2'b01) ? 7'h40 : (x[1:0] == 2'b10) ? 7'h10 : 7'h20;
        check(32'(drive_impedance_ohm), 32'(imp(x[14:12])));
        check(32'(read_latency_cycles), (x[7:4] < 4'hC) ? 32'(x[7:4]) + 32'h5 : 32'h14);
        check(32'(wrap_len_bytes), 32'(wl));
        check(32'(wrap_addr_mask), 32'(wl - 7'h01));
        check(32'({small_sector_en, small_sector_top, password_sector_top}),
            32'({~x[9], x[9:8] == 2'b01, x[8]}));
        check(32'({strobe_stall_en, config_prog_allowed, ssr_prog_allowed}),
            32'({~x[2], x[11], x[10]}));
    endtask

    task automatic wait_dpd(input logic e);
        int n;
        n = 0;
        while (deep_power_down !== e && n < 30)
        begin
            @(posedge pclk);
            n++;
        end
        check(32'(deep_power_down), 32'(e));
    endtask

    // ----
    // Tests
    // ----
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'h3;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(`FCR_OFS_NONVOL, 32'h0000DEBF);
        rd(`FCR_OFS_VOL, 32'h0000DEBF);
        outs(16'hDEBF);
        check(32'(deep_power_down), 32'h0);
        rd(`FCR_OFS_STATUS, 32'h0000041A);
        for (int i = 0; i < 16; i++)
        begin
            v = 16'h8C08 | {1'b0, i[2:0], 12'h000} | {6'h00, i[1:0], i[3:0], 4'h0}
                | {13'h0000, i[0], i[1:0]};
            wr(`FCR_OFS_VOL, v, 1'b0);
            outs(v);
            rd(`FCR_OFS_VOL, {16'h0000, v});
        end
        pstrb <= 4'h1;
        wr(`FCR_OFS_VOL, 16'h005B, 1'b0);
        pstrb <= 4'h3;
        rd(`FCR_OFS_VOL, 32'h0000FF5B);
        rd(`FCR_OFS_NONVOL, 32'h0000DEBF);
        wr(`FCR_OFS_NONVOL, 16'hAC5B, 1'b0);
        rd(`FCR_OFS_VOL, 32'h0000AC5B);
        wr(`FCR_OFS_VOL, 16'hDEBF, 1'b0);
        rd(`FCR_OFS_NONVOL, 32'h0000AC5B);
        wr(`FCR_OFS_CTRL, 16'h0001, 1'b0);
        rd(`FCR_OFS_VOL, 32'h0000AC5B);
        wr(`FCR_OFS_NONVOL, 16'hA85B, 1'b0);
        outs(16'hA85B);
        rd(`FCR_OFS_VOL, 32'h0000A85B);
        wr(`FCR_OFS_VOL, 16'hA05B, 1'b0);
        outs(16'hA05B);
        wr(`FCR_OFS_VOL, 16'hDEBF, 1'b1);
        wr(`FCR_OFS_NONVOL, 16'hDEBF, 1'b1);
        rd(`FCR_OFS_VOL, 32'h0000A05B);
        rd(`FCR_OFS_NONVOL, 32'h0000A85B);
        u_fcr_host_model.hw_reset(4);
        repeat (8) @(posedge pclk);
        rd(`FCR_OFS_VOL, 32'h0000AC5B);
        outs(16'hAC5B);
        wr(`FCR_OFS_CTRL, 16'h0004, 1'b0);
        wait_dpd(1'b1);
        rd(`FCR_OFS_STATUS, 32'h0000029F);
        u_fcr_host_model.cs_pulse();
        wait_dpd(1'b0);
        wr(`FCR_OFS_CTRL, 16'h0004, 1'b0);
        wait_dpd(1'b1);
        u_fcr_host_model.hw_reset(4);
        wait_dpd(1'b0);
        wr(`FCR_OFS_CTRL, 16'h0002, 1'b0);
        rd(`FCR_OFS_NONVOL, 32'h0000FFFF);
        outs(16'hFFFF);
        rd(8'h10, 32'h00000000);
        wr(`FCR_OFS_STATUS, 16'h0000, 1'b1);
        wr(`FCR_OFS_VOL, 16'hF7FF, 1'b0);
        wr(`FCR_OFS_CTRL, 16'h0002, 1'b0);
        rd(`FCR_OFS_VOL, 32'h0000F7FF);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(`FCR_OFS_VOL, 32'h0000DEBF);
        check(32'(deep_power_down), 32'h0);
        finish_test();
    end
endmodule

// [tb/fcr_host_model.sv]
`timescale 1ns/10ps

// ----
// Host pin model
// ----
module fcr_host_model
#(
    parameter int LINK_HALF = 4
)
(
    input wire logic pclk,
    output logic cs_n,
    output logic hw_reset_n
);
    // Select idles high: no link activity between frames
    initial
    begin
        cs_n = 1'b1;
        hw_reset_n = 1'b1;
    end

    task automatic cs_pulse();
        @(posedge pclk);
        cs_n <= 1'b0;
        repeat (LINK_HALF) @(posedge pclk);
        cs_n <= 1'b1;
    endtask

    task automatic hw_reset(input int len);
        @(posedge pclk);
        hw_reset_n <= 1'b0;
        repeat (len) @(posedge pclk);
        hw_reset_n <= 1'b1;
    endtask
endmodule
